// ==== src/rstseq_pkg.sv ====
// Constants shared by the reset sequencer and configuration latch.
// Assumes a single reference clock and active-low board reset pins.
// Contract
// - Reset pins are asynchronous signals that may be asserted at any moment; hard and soft reset are two-way, power-on reset is input only.
// - After power-on reset is released the device drives hard and soft reset low for 4096 cycles.
// - After a valid hard reset is released the internal resets stay active for 4096 more cycles.
// - While hard or power-on reset is asserted the configuration pins are sampled every cycle.
// - Two cycles after both resets are high the configuration word is frozen.
package rstseq_pkg;
  // ****************************************
  // Widths and timing counts
  // ****************************************
  localparam int CFG_WIDTH = 32;
  localparam int REF_CLK_HZ = 40_000_000;
  localparam int MIN_PULSE_CYCLES = 4;
  localparam int STRETCH_CYCLES = 4096;
  localparam int CNT_WIDTH = 13;
  localparam int LOCK_DELAY = 2;
  localparam logic [CFG_WIDTH-1:0] CFG_RESET = 32'h0000_0000;
endpackage : rstseq_pkg

// ==== src/rstseq_top.sv ====
// Reset sequencer: stretches pin and internal resets, latches the configuration word.
// Assumes the board drives the reset pins open-drain with pull-ups, low meaning asserted.
module rstseq_top
  import rstseq_pkg::*;
#(
  parameter int STRETCH = rstseq_pkg::STRETCH_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic powerOnResetPinN,
  input wire logic hardResetPinIn,
  output logic hardResetPinOut,
  output logic hardResetPinOe,
  input wire logic softResetPinIn,
  output logic softResetPinOut,
  output logic softResetPinOe,
  input wire logic [rstseq_pkg::CFG_WIDTH-1:0] cfgPins,
  output logic [rstseq_pkg::CFG_WIDTH-1:0] cfgWord,
  output logic cfgLocked,
  output logic internalReset,
  output logic softResetReq
);
  import rstseq_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  // The pins are asynchronous, so every one passes two flops first.
  logic [2:0] syncA_q, syncA_d, syncB_q, syncB_d;
  logic [CFG_WIDTH-1:0] cfgA_q, cfgB_q;
  logic porN, hardN, softN;

  always_comb
  begin
    syncA_d = {softResetPinIn, hardResetPinIn, powerOnResetPinN};
    syncB_d = syncA_q;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      syncA_q <= 3'h0;
      syncB_q <= 3'h0;
      cfgA_q <= CFG_RESET;
      cfgB_q <= CFG_RESET;
    end
    else
    begin
      syncA_q <= syncA_d;
      syncB_q <= syncB_d;
      cfgA_q <= cfgPins;
      cfgB_q <= cfgA_q;
    end
  end

  assign porN = syncB_q[0];
  assign hardN = syncB_q[1];
  assign softN = syncB_q[2];

  // ****************************************
  // Sequencer
  // ****************************************
  // Our own drive of the hard pin is excluded from the width check so the
  // end of the pin stretch does not restart the internal reset stretch.
  logic [CNT_WIDTH-1:0] pinCnt_q, pinCnt_d, intCnt_q, intCnt_d;
  logic [2:0] hardW_q, hardW_d, softW_q, softW_d;
  logic pinDrv_q, pinDrv_d, intRst_q, intRst_d, porSeen_q, porSeen_d;
  logic softReq_q, softReq_d;
  logic [CFG_WIDTH-1:0] cfg_q, cfg_d;
  logic [1:0] lockCnt_q, lockCnt_d;
  logic locked_q, locked_d;
  logic extHard;

  always_comb
  begin
    extHard = !hardN && !pinDrv_q;
    pinCnt_d = pinCnt_q;
    pinDrv_d = pinDrv_q;
    porSeen_d = porN;
    intCnt_d = intCnt_q;
    intRst_d = intRst_q;
    hardW_d = extHard ? ((hardW_q == 3'(MIN_PULSE_CYCLES)) ? hardW_q : hardW_q + 3'h1) : 3'h0;
    // Our own drive of the soft pin must not count, or the pin stretch ends in a false request.
    softW_d = (!softN && !pinDrv_q) ? ((softW_q == 3'(MIN_PULSE_CYCLES)) ? softW_q : softW_q + 3'h1) : 3'h0;
    softReq_d = 1'b0;
    if (!porN)
    begin
      pinDrv_d = 1'b1;
      pinCnt_d = '0;
      intRst_d = 1'b1;
      intCnt_d = '0;
    end
    else
    begin
      if (!porSeen_q)
      begin
        pinCnt_d = CNT_WIDTH'(STRETCH);
        pinDrv_d = 1'b1;
        intCnt_d = CNT_WIDTH'(STRETCH);
      end
      else if (pinCnt_q != '0)
      begin
        pinCnt_d = pinCnt_q - 1'b1;
        pinDrv_d = (pinCnt_q != CNT_WIDTH'(1));
      end
      if (hardN && !pinDrv_q && hardW_q == 3'(MIN_PULSE_CYCLES))
        intCnt_d = CNT_WIDTH'(STRETCH);
      else if (porSeen_q && intCnt_q != '0)
      begin
        intCnt_d = intCnt_q - 1'b1;
        intRst_d = (intCnt_q != CNT_WIDTH'(1));
      end
      // A valid hard pulse wins over an older stretch that happens to expire now.
      if (extHard && hardW_q >= 3'(MIN_PULSE_CYCLES - 1))
        intRst_d = 1'b1;
      if (softN && softW_q == 3'(MIN_PULSE_CYCLES) && !pinDrv_q)
        softReq_d = 1'b1;
    end
  end

  // ****************************************
  // Configuration word latch
  // ****************************************
  always_comb
  begin
    cfg_d = cfg_q;
    lockCnt_d = lockCnt_q;
    locked_d = locked_q;
    if (!porN || !hardN)
    begin
      cfg_d = cfgB_q;
      lockCnt_d = 2'h0;
      locked_d = 1'b0;
    end
    else if (!locked_q)
    begin
      if (lockCnt_q == 2'(LOCK_DELAY))
        locked_d = 1'b1;
      else
      begin
        cfg_d = cfgB_q;
        lockCnt_d = lockCnt_q + 2'h1;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      pinCnt_q <= '0;
      intCnt_q <= '0;
      hardW_q <= 3'h0;
      softW_q <= 3'h0;
      pinDrv_q <= 1'b1;
      intRst_q <= 1'b1;
      porSeen_q <= 1'b0;
      softReq_q <= 1'b0;
      cfg_q <= CFG_RESET;
      lockCnt_q <= 2'h0;
      locked_q <= 1'b0;
    end
    else
    begin
      pinCnt_q <= pinCnt_d;
      intCnt_q <= intCnt_d;
      hardW_q <= hardW_d;
      softW_q <= softW_d;
      pinDrv_q <= pinDrv_d;
      intRst_q <= intRst_d;
      porSeen_q <= porSeen_d;
      softReq_q <= softReq_d;
      cfg_q <= cfg_d;
      lockCnt_q <= lockCnt_d;
      locked_q <= locked_d;
    end
  end

  assign hardResetPinOut = 1'b0;
  assign softResetPinOut = 1'b0;
  assign hardResetPinOe = pinDrv_q;
  assign softResetPinOe = pinDrv_q;
  assign internalReset = intRst_q;
  assign softResetReq = softReq_q;
  assign cfgWord = cfg_q;
  assign cfgLocked = locked_q;

  // ****************************************
  // Checks
  // ****************************************
  sequence porRelease;
    !porSeen_q && porN;
  endsequence

  chk_por_pin_stretch: assert property (@(posedge ref_clk) disable iff (sys_rst)
    porRelease |=> pinDrv_q [*8])
    else $error("Pin reset not held after power-on release.");

  chk_pin_stretch_end: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (porN && pinCnt_q == CNT_WIDTH'(1)) |=> !pinDrv_q)
    else $error("Pin reset stretch did not end on count.");

  chk_hard_int_stretch: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (porN && hardN && !pinDrv_q && hardW_q == 3'(MIN_PULSE_CYCLES)) |=> intRst_q [*8])
    else $error("Internal reset not stretched after hard reset.");

  chk_por_int_reset: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !porN |=> intRst_q && pinDrv_q)
    else $error("Resets not active during power-on reset.");

  chk_cfg_sample: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!porN || !hardN) |=> cfg_q == $past(cfgB_q) && !locked_q)
    else $error("Configuration word not sampled during reset.");

  chk_cfg_lock_time: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (porN && hardN && !locked_q && lockCnt_q == 2'h0) ##1 (porN && hardN) [*2] |=> locked_q)
    else $error("Configuration word not locked two cycles after release.");

  chk_cfg_frozen: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (locked_q && porN && hardN) |=> $stable(cfg_q))
    else $error("Configuration word changed after lock.");

  chk_sync_delay: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $fell(powerOnResetPinN) ##1 !powerOnResetPinN |=> !porN)
    else $error("Power-on reset synchroniser delay wrong.");

  chk_sync_rise: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(powerOnResetPinN) ##1 powerOnResetPinN |=> porN)
    else $error("Power-on reset release synchroniser delay wrong.");
endmodule : rstseq_top

// ==== verification/rstseq_board.sv ====
// Board reset supervisor and strap pins facing the reset sequencer.
// Assumes pull-ups on the hard and soft reset wires, low meaning asserted.
module rstseq_board
(
  input wire logic porHold,
  input wire logic hardHold,
  input wire logic softHold,
  input wire logic [31:0] strapValue,
  input wire logic hardResetPinOut,
  input wire logic hardResetPinOe,
  input wire logic softResetPinOut,
  input wire logic softResetPinOe,
  output logic powerOnResetPinN,
  output logic hardResetPinIn,
  output logic softResetPinIn,
  output logic [31:0] cfgPins
);
  timeunit 1ns;
  timeprecision 1ps;
  // A clean level with no glitches; the hold time comes from the bench.
  assign powerOnResetPinN = ~porHold;
  // The wire is pulled up, so it goes high once no party pulls it low.
  assign hardResetPinIn = ~((hardResetPinOe & ~hardResetPinOut) | hardHold);
  assign softResetPinIn = ~((softResetPinOe & ~softResetPinOut) | softHold);
  assign cfgPins = strapValue;
endmodule : rstseq_board

// ==== verification/tb_top.sv ====
// Self-checking bench for the reset sequencer with a short stretch count.
// Assumes the board model resolves the pins and inputs move 2 ns after the edge.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rstseq_pkg::*;
  localparam int STR = 16;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic porHold = 1'b1;
  logic hardHold = 1'b0;
  logic softHold = 1'b0;
  logic [CFG_WIDTH-1:0] strap = 32'hA5A5_1234;
  logic porN, hIn, hOut, hOe, sIn, sOut, sOe, cfgLocked, internalReset, softResetReq;
  logic [CFG_WIDTH-1:0] cfgPins, cfgWord;
  int mismatches = 0;
  int tests_run = 0;
  always #12.5 ref_clk = ~ref_clk;
  rstseq_board board (.porHold(porHold), .hardHold(hardHold), .softHold(softHold),
    .strapValue(strap), .hardResetPinOut(hOut), .hardResetPinOe(hOe), .softResetPinOut(sOut),
    .softResetPinOe(sOe), .powerOnResetPinN(porN), .hardResetPinIn(hIn), .softResetPinIn(sIn),
    .cfgPins(cfgPins));
  rstseq_top #(.STRETCH(STR)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .powerOnResetPinN(porN),
    .hardResetPinIn(hIn), .hardResetPinOut(hOut), .hardResetPinOe(hOe), .softResetPinIn(sIn),
    .softResetPinOut(sOut), .softResetPinOe(sOe), .cfgPins(cfgPins), .cfgWord(cfgWord),
    .cfgLocked(cfgLocked), .internalReset(internalReset), .softResetReq(softResetReq));
  task automatic tally_and_finish();
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : tick
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask : check_val
  task automatic check_span(input int got, input int lo, input int hi, input string what);
    tests_run++;
    if (got < lo || got > hi)
    begin
      mismatches++;
      $display("CHECK FAILED %0t %s %0d", $time, what, got);
    end
  endtask : check_span
  // Counts cycles while the pin enable or the internal reset stays high, bounded.
  task automatic high_span(input bit pinSide, output int n);
    n = 0;
    while ((pinSide ? hOe : internalReset) === 1'b1)
    begin
      tick(1);
      n++;
      if (n > 4 * STR)
      begin
        mismatches++;
        tally_and_finish();
      end
    end
  endtask : high_span
  task automatic por_seq(input logic [31:0] word);
    int n;
    strap = word;
    porHold = 1'b1;
    tick(6);
    check_val(cfgWord, word, "word during por");
    check_val(cfgLocked, 1'b0, "locked during por");
    porHold = 1'b0;
    tick(1);
    check_val({hOe, sOe}, 2'b11, "both pins driven after por");
    high_span(1'b1, n);
    check_span(n, STR, STR + 6, "pin stretch");
    n = 0;
    repeat (6)
    begin
      tick(1);
      n += (softResetReq === 1'b1);
    end
    check_span(n, 0, 0, "own pin drive taken as soft reset");
    check_val(cfgLocked, 1'b1, "lock after por");
    strap = ~word;
    tick(4);
    check_val(cfgWord, word, "frozen word");
  endtask : por_seq
  task automatic hard_seq(input int width, input bit valid);
    int n;
    strap = 32'h3C3C_0001 + width;
    hardHold = 1'b1;
    tick(width);
    hardHold = 1'b0;
    if (valid)
    begin
      // The internal reset rises only once the fourth low cycle has crossed the synchroniser.
      for (n = 0; n < 4 && internalReset !== 1'b1; n++)
        tick(1);
      check_val(internalReset, 1'b1, "internal reset raised");
      high_span(1'b0, n);
      check_span(n, STR, STR + 6, "internal stretch");
      tick(6);
      check_val(cfgWord, strap, "word from hard");
      check_val(cfgLocked, 1'b1, "lock after hard");
    end
    else
      repeat (10)
      begin
        tick(1);
        check_val(internalReset, 1'b0, "short hard pulse");
      end
  endtask : hard_seq
  task automatic soft_seq(input int width, input int pulses);
    int n;
    n = 0;
    softHold = 1'b1;
    tick(width);
    softHold = 1'b0;
    repeat (10)
    begin
      tick(1);
      n += (softResetReq === 1'b1);
    end
    check_span(n, pulses, pulses, "soft request pulses");
  endtask : soft_seq
  initial
  begin
    tick(8);
    sys_rst = 1'b0;
    por_seq(32'hA5A5_1234);
    hard_seq(3, 1'b0);
    hard_seq(4, 1'b1);
    soft_seq(3, 0);
    soft_seq(4, 1);
    por_seq(32'h5A5A_0F0F);
    tally_and_finish();
  end
endmodule : tb_top
